// *** logic/tcr_pkg.sv ***
// Package with command codes, scratchpad layout, reset values and timing for the sequencer.
package tcr_pkg;

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] SELECT_ALL_COMMAND       = 8'hCC;
   localparam logic [7:0] SELECT_ONE_COMMAND       = 8'h55;
   localparam logic [7:0] START_CONVERSION_COMMAND = 8'h44;
   localparam logic [7:0] READ_SCRATCHPAD_COMMAND  = 8'hBE;

   // ---------------------------------------------------------------
   // Scratchpad layout
   // ---------------------------------------------------------------
   localparam logic [7:0] RESERVED_BYTE    = 8'hFF;
   localparam int         ID_BYTES         = 8;
   localparam int         GROUP_BYTES      = 8;
   localparam logic [4:0] CRC_ONE_INDEX    = 5'h08;
   localparam logic [4:0] CRC_TWO_INDEX    = 5'h11;
   localparam logic [4:0] LAST_INDEX       = 5'h11;
   localparam logic [7:0] CRC_POLY_REFLECT = 8'h8C;

   // ---------------------------------------------------------------
   // Reset values of the held registers
   // ---------------------------------------------------------------
   localparam logic [7:0] RESULT_LOW_RESET     = 8'h00;
   localparam logic [7:0] RESULT_HIGH_RESET    = 8'h00;
   localparam logic [7:0] CONFIG_ONE_RESET     = 8'h00;
   localparam logic [7:0] CONFIG_TWO_RESET     = 8'h00;
   localparam logic [7:0] SHORT_ADDRESS_RESET  = 8'h00;
   localparam logic [7:0] ALERT_LOW_LOW_RESET  = 8'h00;
   localparam logic [7:0] ALERT_LOW_HIGH_RESET = 8'h00;
   localparam logic [7:0] ALERT_HIGH_LOW_RESET = 8'h00;
   localparam logic [7:0] ALERT_HIGH_HI_RESET  = 8'h00;
   localparam logic [7:0] TRIM_LOW_RESET       = 8'h00;
   localparam logic [7:0] TRIM_HIGH_RESET      = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLOCK_MHZ            = 250;
   localparam int START_DELAY_TIME_NS  = 1000;
   localparam int START_DELAY_CYCLES   = (START_DELAY_TIME_NS * CLOCK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      TCR_IDLE,
      TCR_ADDR,
      TCR_MATCH,
      TCR_FUNC,
      TCR_READ,
      TCR_MUTE
   } tcr_state_t;

endpackage : tcr_pkg

// *** logic/tcr_sequencer.sv ***
// Command sequencer for conversion start and scratchpad read-back on a single-wire sensor.
//
// Function
// - Answer every bus reset with presence pulse.
// - Select-all code CCh addresses this device.
// - Code 44h starts conversion, then stores result.
// - Code 55h plus matching 8-byte identifier selects.
// - Code BEh streams scratchpad from first byte.
// - First group: result, status, config, CRC.
// - Second group: alerts, trim, reserved, CRC.
// - Bus reset abandons read and restarts normally.
`timescale 1ns/1ps

module tcr_sequencer
   import tcr_pkg::*;
#(
   parameter logic [63:0] DEVICE_ID          = 64'h0123_4567_89AB_CDEF, // Arbitrary value.
   parameter int          START_DELAY_COUNT  = START_DELAY_CYCLES
) (
   input  wire logic       ref_clk_i,        // Device clock, 250 MHz.
   input  wire logic       reset_i,          // Synchronous reset, active high.
   input  wire logic       bus_reset_i,      // Pulse: host reset pulse seen on the bus.
   input  wire logic       rx_valid_i,       // Pulse: a received byte is complete.
   input  wire logic [7:0] rx_byte_i,        // Received byte, assembled LSB first.
   input  wire logic       tx_req_i,         // Pulse: host starts reading a byte.
   input  wire logic       conv_done_i,      // Pulse: converter has a new result.
   input  wire logic [15:0] conv_result_i,   // Converter result word.
   input  wire logic [7:0] status_i,         // Live device status byte.
   output logic            presence_o,       // Pulse: send presence response.
   output logic            tx_valid_o,       // Pulse: tx_byte_o is ready to shift out.
   output logic [7:0]      tx_byte_o,        // Byte to send, LSB first.
   output logic            conv_start_o,     // Pulse: start the converter.
   output logic            conv_busy_o,      // Level: conversion in progress.
   output logic            selected_o        // Level: device addressed in this frame.
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      logic       fb;
      c  = crc;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         fb = c[0] ^ data[i];
         c  = {1'b0, c[7:1]};
         if (fb) begin
            c = c ^ CRC_POLY_REFLECT;
         end
      end
      return c;
   endfunction : crc8_byte

   function automatic logic [7:0] id_byte(input logic [2:0] idx);
      logic [63:0] sh;
      sh = DEVICE_ID >> {idx, 3'b000};
      return sh[7:0];
   endfunction : id_byte

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   tcr_state_t  state_r, state_nxt;
   logic [2:0]  id_idx_r, id_idx_nxt;
   logic [4:0]  rd_idx_r, rd_idx_nxt;
   logic [7:0]  crc_r, crc_nxt;
   logic        presence_r, presence_nxt;
   logic        tx_valid_r, tx_valid_nxt;
   logic [7:0]  tx_byte_r, tx_byte_nxt;
   logic        selected_r, selected_nxt;

   logic        conv_pend_r, conv_pend_nxt;
   logic        conv_busy_r, conv_busy_nxt;
   logic        conv_start_r, conv_start_nxt;
   logic [31:0] delay_cnt_r, delay_cnt_nxt;
   logic [7:0]  result_low_r, result_low_nxt;
   logic [7:0]  result_high_r, result_high_nxt;

   logic [7:0]  data_byte;

   // ---------------------------------------------------------------
   // Scratchpad byte selection
   // ---------------------------------------------------------------
   always_comb begin
      case (rd_idx_r)
         5'h00:   data_byte = result_low_r;
         5'h01:   data_byte = result_high_r;
         5'h02:   data_byte = status_i;
         5'h03:   data_byte = RESERVED_BYTE;
         5'h04:   data_byte = CONFIG_ONE_RESET;
         5'h05:   data_byte = CONFIG_TWO_RESET;
         5'h06:   data_byte = SHORT_ADDRESS_RESET;
         5'h07:   data_byte = RESERVED_BYTE;
         5'h09:   data_byte = ALERT_LOW_LOW_RESET;
         5'h0A:   data_byte = ALERT_LOW_HIGH_RESET;
         5'h0B:   data_byte = ALERT_HIGH_LOW_RESET;
         5'h0C:   data_byte = ALERT_HIGH_HI_RESET;
         5'h0D:   data_byte = TRIM_LOW_RESET;
         5'h0E:   data_byte = TRIM_HIGH_RESET;
         default: data_byte = RESERVED_BYTE;
      endcase
   end

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt     = state_r;
      id_idx_nxt    = id_idx_r;
      rd_idx_nxt    = rd_idx_r;
      crc_nxt       = crc_r;
      presence_nxt  = 1'b0;
      tx_valid_nxt  = 1'b0;
      tx_byte_nxt   = tx_byte_r;
      selected_nxt  = selected_r;
      conv_pend_nxt = 1'b0;
      if (bus_reset_i) begin
         // A reset wins over every sequencer step in flight, including a half-read scratchpad; a running conversion goes on.
         presence_nxt = 1'b1;
         state_nxt    = TCR_ADDR;
         selected_nxt = 1'b0;
         id_idx_nxt   = 3'h0;
         rd_idx_nxt   = 5'h00;
         crc_nxt      = 8'h00;
      end else begin
         case (state_r)
            TCR_IDLE: begin
               state_nxt = TCR_IDLE;
            end
            TCR_ADDR: begin
               if (rx_valid_i) begin
                  if (rx_byte_i == SELECT_ALL_COMMAND) begin
                     state_nxt    = TCR_FUNC;
                     selected_nxt = 1'b1;
                  end else if (rx_byte_i == SELECT_ONE_COMMAND) begin
                     state_nxt = TCR_MATCH;
                  end else begin
                     state_nxt = TCR_MUTE;
                  end
               end
            end
            TCR_MATCH: begin
               if (rx_valid_i) begin
                  if (rx_byte_i != id_byte(id_idx_r)) begin
                     state_nxt = TCR_MUTE;
                  end else if (id_idx_r == 3'(ID_BYTES - 1)) begin
                     state_nxt    = TCR_FUNC;
                     selected_nxt = 1'b1;
                  end else begin
                     id_idx_nxt = id_idx_r + 3'h1;
                  end
               end
            end
            TCR_FUNC: begin
               if (rx_valid_i) begin
                  if (rx_byte_i == START_CONVERSION_COMMAND) begin
                     conv_pend_nxt = 1'b1;
                     state_nxt     = TCR_MUTE;
                  end else if (rx_byte_i == READ_SCRATCHPAD_COMMAND) begin
                     state_nxt  = TCR_READ;
                     rd_idx_nxt = 5'h00;
                     crc_nxt    = 8'h00;
                  end else begin
                     state_nxt = TCR_MUTE;
                  end
               end
            end
            TCR_READ: begin
               if (tx_req_i) begin
                  // Bytes are only offered on a host-started read slot.
                  tx_valid_nxt = 1'b1;
                  if (rd_idx_r == CRC_ONE_INDEX || rd_idx_r == CRC_TWO_INDEX) begin
                     tx_byte_nxt = crc_r;
                     crc_nxt     = 8'h00;
                  end else if (rd_idx_r > LAST_INDEX) begin
                     tx_byte_nxt = RESERVED_BYTE;
                  end else begin
                     tx_byte_nxt = data_byte;
                     crc_nxt     = crc8_byte(crc_r, data_byte);
                  end
                  if (rd_idx_r <= LAST_INDEX) begin
                     rd_idx_nxt = rd_idx_r + 5'h01;
                  end
               end
            end
            TCR_MUTE: begin
               state_nxt = TCR_MUTE;
            end
            default: begin
               state_nxt = TCR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r    <= TCR_IDLE;
         id_idx_r   <= 3'h0;
         rd_idx_r   <= 5'h00;
         crc_r      <= 8'h00;
         presence_r <= 1'b0;
         tx_valid_r <= 1'b0;
         tx_byte_r  <= 8'hFF;
         selected_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         id_idx_r   <= id_idx_nxt;
         rd_idx_r   <= rd_idx_nxt;
         crc_r      <= crc_nxt;
         presence_r <= presence_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_byte_r  <= tx_byte_nxt;
         selected_r <= selected_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Conversion control
   // ---------------------------------------------------------------
   // The conversion runs on its own, so a host reset during it does not cancel it;
   // the host is expected to wait out the start delay plus conversion time anyway.
   always_comb begin
      conv_busy_nxt   = conv_busy_r;
      conv_start_nxt  = 1'b0;
      delay_cnt_nxt   = delay_cnt_r;
      result_low_nxt  = result_low_r;
      result_high_nxt = result_high_r;
      if (conv_pend_r && !conv_busy_r) begin
         conv_busy_nxt = 1'b1;
         delay_cnt_nxt = 32'(START_DELAY_COUNT);
      end else if (conv_busy_r) begin
         if (delay_cnt_r > 32'd1) begin
            delay_cnt_nxt = delay_cnt_r - 32'd1;
         end else if (delay_cnt_r == 32'd1) begin
            delay_cnt_nxt  = 32'd0;
            conv_start_nxt = 1'b1;
         end else if (conv_done_i) begin
            conv_busy_nxt   = 1'b0;
            result_low_nxt  = conv_result_i[7:0];
            result_high_nxt = conv_result_i[15:8];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         conv_pend_r   <= 1'b0;
         conv_busy_r   <= 1'b0;
         conv_start_r  <= 1'b0;
         delay_cnt_r   <= 32'd0;
         result_low_r  <= RESULT_LOW_RESET;
         result_high_r <= RESULT_HIGH_RESET;
      end else begin
         conv_pend_r   <= conv_pend_nxt;
         conv_busy_r   <= conv_busy_nxt;
         conv_start_r  <= conv_start_nxt;
         delay_cnt_r   <= delay_cnt_nxt;
         result_low_r  <= result_low_nxt;
         result_high_r <= result_high_nxt;
      end
   end

   assign presence_o   = presence_r;
   assign tx_valid_o   = tx_valid_r;
   assign tx_byte_o    = tx_byte_r;
   assign conv_start_o = conv_start_r;
   assign conv_busy_o  = conv_busy_r;
   assign selected_o   = selected_r;

endmodule : tcr_sequencer

// *** tb/tcr_sequencer_properties.sv ***
// Port checker for the command sequencer.
`timescale 1ns/1ps
module tcr_sequencer_checker
   import tcr_pkg::*;
#(
   parameter int START_DELAY_COUNT = START_DELAY_CYCLES
) (
   input wire logic       ref_clk_i,    // Clock.
   input wire logic       reset_i,      // Reset.
   input wire logic       bus_reset_i,  // Bus reset.
   input wire logic       rx_valid_i,   // Byte in.
   input wire logic [7:0] rx_byte_i,    // Byte value.
   input wire logic       tx_req_i,     // Read request.
   input wire logic       conv_done_i,  // Converter done.
   input wire logic       presence_o,   // Presence.
   input wire logic       tx_valid_o,   // Byte out.
   input wire logic [7:0] tx_byte_o,    // Byte out value.
   input wire logic       conv_start_o, // Converter start.
   input wire logic       conv_busy_o,  // Busy.
   input wire logic       selected_o    // Addressed.
);
   logic [15:0] busy_cnt_r;
   logic [15:0] busy_cnt_nxt;
   // Counts cycles since busy rose, so the start delay is checked without long repetition.
   always_comb busy_cnt_nxt = conv_busy_o ? busy_cnt_r + 16'h0001 : 16'h0000;
   always_ff @(posedge ref_clk_i) begin
      busy_cnt_r <= reset_i ? 16'h0000 : busy_cnt_nxt;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_busy_rise;
      !conv_busy_o ##1 conv_busy_o;
   endsequence
   sequence s_start_cmd;
      rx_valid_i && rx_byte_i == START_CONVERSION_COMMAND;
   endsequence
   a_presence_answer: assert property (bus_reset_i |=> presence_o)
      else $error("presence missing");
   a_presence_cause: assert property (presence_o |-> $past(bus_reset_i))
      else $error("presence without bus reset");
   a_tx_cause: assert property (tx_valid_o |-> $past(tx_req_i) && $past(selected_o))
      else $error("byte sent without request");
   a_tx_hold: assert property (!tx_valid_o |-> $stable(tx_byte_o))
      else $error("send byte changed");
   a_select_drop: assert property (bus_reset_i |=> !selected_o)
      else $error("selection kept over bus reset");
   a_select_cause: assert property ($rose(selected_o) |-> $past(rx_valid_i))
      else $error("selection without byte");
   a_busy_cause: assert property (s_busy_rise |-> $past(rx_valid_i, 2)
      && $past(rx_byte_i, 2) == START_CONVERSION_COMMAND) else $error("busy without command");
   a_start_delay: assert property (conv_start_o |-> conv_busy_o
      && busy_cnt_r == 16'(START_DELAY_COUNT)) else $error("start delay wrong");
   a_busy_fall: assert property ($fell(conv_busy_o) |-> $past(conv_done_i))
      else $error("busy fell without done");
   c_start: cover property (s_start_cmd ##2 conv_busy_o);
endmodule : tcr_sequencer_checker

bind tcr_sequencer tcr_sequencer_checker #(.START_DELAY_COUNT(START_DELAY_COUNT)) u_checker (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_reset_i(bus_reset_i),
   .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .tx_req_i(tx_req_i),
   .conv_done_i(conv_done_i), .presence_o(presence_o), .tx_valid_o(tx_valid_o),
   .tx_byte_o(tx_byte_o), .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o),
   .selected_o(selected_o));

// *** tb/tcr_host_model.sv ***
// Byte-level model of the bus host and its slot interface.
`timescale 1ns/1ps
module tcr_host_model (
   input  wire logic       clk_i,       // Clock.
   output logic            bus_reset_o, // Bus reset pulse.
   output logic            rx_valid_o,  // Byte written.
   output logic [7:0]      rx_byte_o,   // Byte value.
   output logic            tx_req_o     // Read slot start.
);
   initial begin
      bus_reset_o = 1'b0;
      rx_valid_o  = 1'b0;
      rx_byte_o   = 8'h00;
      tx_req_o    = 1'b0;
   end
   // Every frame opens with a bus reset.
   task automatic pulse_reset();
      @(posedge clk_i);
      bus_reset_o <= 1'b1;
      @(posedge clk_i);
      bus_reset_o <= 1'b0;
   endtask : pulse_reset
   // A gap models a slow host; the byte lines show the inverse once released.
   task automatic send(input logic [7:0] b, input int gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o  <= b;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o  <= ~b;
   endtask : send
   // One request per byte read.
   task automatic read();
      @(posedge clk_i);
      tx_req_o <= 1'b1;
      @(posedge clk_i);
      tx_req_o <= 1'b0;
   endtask : read
endmodule : tcr_host_model

// *** tb/tb_temp_convert_read_sequencer.sv ***
// Self-checking testbench for the command sequencer.
`timescale 1ns/1ps
module tb_temp_convert_read_sequencer;
   import tcr_pkg::*;
   localparam logic [63:0] TB_ID = 64'hA1B2_C3D4_E5F6_0718; // Arbitrary value.
   localparam int          DLY   = 4;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, conv_done_i = 1'b0;
   logic [15:0] conv_result_i = 16'h0000;
   logic [7:0] status_i = 8'h5A, rx_byte_i, tx_byte_o;
   logic bus_reset_i, rx_valid_i, tx_req_i, presence_o, tx_valid_o;
   logic conv_start_o, conv_busy_o, selected_o;
   int n_fail = 0, n_checks = 0, cnt;
   logic [7:0] exp_q[$];
   always #2 ref_clk_i = ~ref_clk_i;
   tcr_host_model host (.clk_i(ref_clk_i), .bus_reset_o(bus_reset_i), .rx_valid_o(rx_valid_i),
      .rx_byte_o(rx_byte_i), .tx_req_o(tx_req_i));
   tcr_sequencer #(.DEVICE_ID(TB_ID), .START_DELAY_COUNT(DLY)) dut (.ref_clk_i(ref_clk_i),
      .reset_i(reset_i), .bus_reset_i(bus_reset_i), .rx_valid_i(rx_valid_i),
      .rx_byte_i(rx_byte_i), .tx_req_i(tx_req_i), .conv_done_i(conv_done_i),
      .conv_result_i(conv_result_i), .status_i(status_i), .presence_o(presence_o),
      .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .conv_start_o(conv_start_o),
      .conv_busy_o(conv_busy_o), .selected_o(selected_o));
   task automatic chk1(input string what, input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk1
   task automatic chk8(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk8
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? CRC_POLY_REFLECT : 8'h00);
      return c;
   endfunction : crc8
   task automatic build_exp(input logic [15:0] res);
      logic [7:0] g[2][8];
      logic [7:0] c;
      g[0] = '{res[7:0], res[15:8], status_i, RESERVED_BYTE, CONFIG_ONE_RESET,
               CONFIG_TWO_RESET, SHORT_ADDRESS_RESET, RESERVED_BYTE};
      g[1] = '{ALERT_LOW_LOW_RESET, ALERT_LOW_HIGH_RESET, ALERT_HIGH_LOW_RESET,
               ALERT_HIGH_HI_RESET, TRIM_LOW_RESET, TRIM_HIGH_RESET, RESERVED_BYTE, RESERVED_BYTE};
      exp_q = {};
      for (int k = 0; k < 2; k++) begin
         c = 8'h00;
         for (int j = 0; j < GROUP_BYTES; j++) begin
            exp_q.push_back(g[k][j]);
            c = crc8(c, g[k][j]);
         end
         exp_q.push_back(c);
      end
      exp_q.push_back(RESERVED_BYTE);
   endtask : build_exp
   task automatic start_frame();
      host.pulse_reset();
      #1 chk1("presence", presence_o, 1'b1);
   endtask : start_frame
   task automatic send_id(input logic [63:0] id);
      for (int i = 0; i < ID_BYTES; i++) host.send(id[8*i +: 8], i % 2);
   endtask : send_id
   task automatic read_chk(input int n);
      for (int i = 0; i < n; i++) begin
         host.read();
         #1 chk1("tx valid", tx_valid_o, 1'b1);
         chk8("tx byte", tx_byte_o, exp_q[i]);
      end
   endtask : read_chk
   task automatic conclude();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      repeat (10) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 chk8("tx idle", tx_byte_o, RESERVED_BYTE);
      chk1("selected idle", selected_o, 1'b0);
      // Bytes before the first bus reset must be ignored.
      host.send(SELECT_ALL_COMMAND, 0);
      #1 chk1("sel before frame", selected_o, 1'b0);
      $display("test reset done");
      start_frame();
      host.send(SELECT_ALL_COMMAND, 0);
      #1 chk1("selected", selected_o, 1'b1);
      host.send(START_CONVERSION_COMMAND, 2);
      @(posedge ref_clk_i);
      #1 chk1("busy", conv_busy_o, 1'b1);
      cnt = 0;
      while (conv_start_o !== 1'b1 && cnt < 100) begin
         @(posedge ref_clk_i);
         #1 cnt++;
      end
      chk8("start delay", 8'(cnt), 8'(DLY));
      @(posedge ref_clk_i);
      conv_done_i   <= 1'b1;
      conv_result_i <= 16'hA5C3;
      @(posedge ref_clk_i);
      conv_done_i   <= 1'b0;
      conv_result_i <= 16'h0000;
      #1 chk1("busy end", conv_busy_o, 1'b0);
      $display("test conversion done");
      build_exp(16'hA5C3);
      start_frame();
      host.send(SELECT_ALL_COMMAND, 1);
      host.read();
      #1 chk1("early read", tx_valid_o, 1'b0);
      host.send(READ_SCRATCHPAD_COMMAND, 0);
      read_chk(19);
      $display("test full read done");
      start_frame();
      host.send(SELECT_ONE_COMMAND, 0);
      send_id(TB_ID ^ 64'h8000_0000_0000_0000);
      host.send(READ_SCRATCHPAD_COMMAND, 0);
      host.read();
      #1 chk1("other id read", tx_valid_o, 1'b0);
      chk1("other id sel", selected_o, 1'b0);
      start_frame();
      host.send(SELECT_ONE_COMMAND, 3);
      send_id(TB_ID);
      #1 chk1("id selected", selected_o, 1'b1);
      host.send(READ_SCRATCHPAD_COMMAND, 0);
      read_chk(2);
      start_frame();
      chk1("sel after abort", selected_o, 1'b0);
      host.send(SELECT_ALL_COMMAND, 0);
      host.send(READ_SCRATCHPAD_COMMAND, 0);
      read_chk(3);
      start_frame();
      host.send(8'h5A, 0);
      host.send(SELECT_ALL_COMMAND, 0);
      #1 chk1("sel after bad addr", selected_o, 1'b0);
      start_frame();
      host.send(SELECT_ALL_COMMAND, 0);
      host.send(8'h00, 0);
      host.send(READ_SCRATCHPAD_COMMAND, 0);
      host.read();
      #1 chk1("read after bad func", tx_valid_o, 1'b0);
      $display("test addressing and abort done");
      conclude();
   end
   // The tests need well under two thousand cycles, so this limit only cuts a hang.
   initial begin
      #20000;
      n_fail++;
      $display("ERROR %0t watchdog expired", $time);
      conclude();
   end
endmodule : tb_temp_convert_read_sequencer
